/* shared/mbt_map.vh */
// constants for the marker block mover: map, field positions, codes
// assumes a 32-bit AXI4-Lite slave with 12-bit byte addresses
`ifndef MBT_MAP_VH
`define MBT_MAP_VH
`define MBT_INST        32
`define MBT_AW          12
`define MBT_MEM_BYTES   20'h00180
`define MBT_CNT_MAX     16'h017F
`define MBT_CNT_MIN     16'h0001
// instance window 0x000-0x1FF: instance in addr[8:4], register in addr[3:2]
`define MBT_WIN_INST    3'h0
`define MBT_REG_CFG     2'h0
`define MBT_REG_SRC     2'h1
`define MBT_REG_DST     2'h2
`define MBT_REG_CNT     2'h3
`define MBT_ADDR_BUSY   12'h200
`define MBT_ADDR_ERR    12'h204
// marker memory window 0x800-0xDFF, one byte per word
`define MBT_MEM_SEL     1'h1
// configuration fields
`define MBT_CFG_COPY    0
`define MBT_CFG_VIS     1
`define MBT_CFG_SKIND   5:4
`define MBT_CFG_DKIND   7:6
`define MBT_CFG_RST     8'h02
// operand kinds
`define MBT_KIND_OFS    2'h0
`define MBT_KIND_BYTE   2'h1
`define MBT_KIND_WORD   2'h2
`define MBT_KIND_DWORD  2'h3
`define MBT_RESP_OKAY   2'h0
`define MBT_RESP_SLVERR 2'h2
`endif

/* hdl/mbt_block_mover.v */
// marker block mover: 32 copy/fill instances over a 384-byte marker memory
// assumes synchronous inputs on MCLK and an AXI4-Lite master on the bus
//
// What this block does
// - copy ranges, or fill range with one byte
// - thirty-two instances with own trigger and flags
// - start only on trigger rising edge
// - flag one: count runs past range end
// - flag two: source and destination ranges overlap
// - mode setting selects copy or fill
// - mode resets to fill
// - parameter visibility setting, resets to visible
// - count accepted from 1 to 383
// - first input source, second destination, count
// - marker operand gives its own byte position
// - numeric operand is offset from first byte
// - word x at 2(x-1), dword x at 4(x-1)
// - offsets reach to end of marker memory
// - flag three: start or count out of range
// - no write while flagged; request dropped
// - fill reads one source byte, writes all
// - flags evaluated always, trigger or not
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`include "mbt_map.vh"
`default_nettype none
module mbt_block_mover (
  input  wire        MCLK,
  input  wire        RESET_N,
  input  wire [31:0] TRIGGER,
  output reg  [31:0] RANGE_EXCEEDED,
  output reg  [31:0] RANGE_OVERLAP,
  output reg  [31:0] BAD_OFFSET,
  output reg  [31:0] BUSY,
  output reg  [31:0] PARAM_VISIBLE,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FRD  = 2'h1;
  localparam [1:0] ST_MOVE = 2'h2;

  // per-instance parameters and the marker memory itself
  reg  [7:0]  cfg_mem  [0:31];
  reg  [15:0] src_mem  [0:31];
  reg  [15:0] dst_mem  [0:31];
  reg  [15:0] cnt_mem  [0:31];
  reg  [7:0]  mark_mem [0:383];

  wire [31:0]  exc_w;
  wire [31:0]  ovl_w;
  wire [31:0]  bad_w;
  wire [287:0] sstart_w;
  wire [287:0] dstart_w;

  // marker operand to byte position; a zero marker number is caught as bad
  function [19:0] start_of;
    input [1:0]  kind;
    input [15:0] val;
    reg   [17:0] m;
    begin
      m = {2'h0, val} - 18'h00001;
      case (kind)
        `MBT_KIND_OFS: start_of = {4'h0, val};
        `MBT_KIND_BYTE:  start_of = {2'h0, m};
        `MBT_KIND_WORD:  start_of = {1'h0, m[17:0], 1'h0};
        `MBT_KIND_DWORD: start_of = {m[17:0], 2'h0};
        default:       start_of = {4'h0, val};
      endcase
    end
  endfunction

  // error checks run every cycle for every instance, trigger or not
  genvar g;
  generate
    for (g = 0; g < `MBT_INST; g = g + 1)
    begin : g_inst
      wire [7:0]  c    = cfg_mem[g];
      wire        is_copy = c[`MBT_CFG_COPY];
      wire [19:0] s    = start_of(c[`MBT_CFG_SKIND], src_mem[g]);
      wire [19:0] d    = start_of(c[`MBT_CFG_DKIND], dst_mem[g]);
      wire [19:0] n    = {4'h0, cnt_mem[g]};
      wire [19:0] se   = s + (is_copy ? n : {4'h0, `MBT_CNT_MIN});
      wire [19:0] de   = d + n;
      wire        zero = (c[`MBT_CFG_SKIND] != `MBT_KIND_OFS && src_mem[g] == 16'h0000) ||
                         (c[`MBT_CFG_DKIND] != `MBT_KIND_OFS && dst_mem[g] == 16'h0000);
      // offsets are checked against the whole memory, not marker reach
      wire        bad  = zero || s >= `MBT_MEM_BYTES || d >= `MBT_MEM_BYTES ||
                         cnt_mem[g] < `MBT_CNT_MIN || cnt_mem[g] > `MBT_CNT_MAX;
      assign bad_w[g] = bad;
      assign exc_w[g] = !bad && (se > `MBT_MEM_BYTES || de > `MBT_MEM_BYTES);
      assign ovl_w[g] = !bad && (is_copy ? (s < de && d < se) : (s >= d && s < de));
      assign sstart_w[g*9 +: 9] = s[8:0];
      assign dstart_w[g*9 +: 9] = d[8:0];
    end
  endgenerate

  wire [31:0] err_w  = exc_w | ovl_w | bad_w;
  reg  [31:0] trig_prev_ff;
  reg  [31:0] pend_ff;
  reg  [1:0]  state_ff;
  reg  [4:0]  inst_ff;
  reg  [8:0]  src_ff;
  reg  [8:0]  dst_ff;
  reg  [8:0]  left_ff;
  reg         copy_ff;
  reg  [7:0]  fill_ff;
  reg  [31:0] done_w;

  // lowest pending instance wins the single engine
  reg  [4:0]  pick;
  reg         any_pend;
  integer     k;
  always @*
  begin
    pick     = 5'h00;
    any_pend = 1'b0;
    for (k = `MBT_INST - 1; k >= 0; k = k - 1)
      if (pend_ff[k])
      begin
        pick     = k[4:0];
        any_pend = 1'b1;
      end
  end

  // rising edge only, and only while that instance is idle and clean
  wire [31:0] edge_w = TRIGGER & ~trig_prev_ff;
  wire [31:0] take_w = edge_w & ~pend_ff & ~err_w;
  wire        last_w = (state_ff == ST_MOVE) && (left_ff == 9'h001);

  always @*
  begin
    done_w = 32'h00000000;
    if (last_w)
      done_w[inst_ff] = 1'b1;
    if (state_ff == ST_IDLE && any_pend && err_w[pick])
      done_w[pick] = 1'b1;
  end

  // trigger history, pending set and status outputs
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      trig_prev_ff   <= 32'h00000000;
      pend_ff        <= 32'h00000000;
      BUSY           <= 32'h00000000;
      RANGE_EXCEEDED <= 32'h00000000;
      RANGE_OVERLAP  <= 32'h00000000;
      BAD_OFFSET     <= 32'h00000000;
    end
    else
    begin
      trig_prev_ff   <= TRIGGER;
      pend_ff        <= (pend_ff & ~done_w) | take_w;
      BUSY           <= (pend_ff & ~done_w) | take_w;
      RANGE_EXCEEDED <= exc_w;
      RANGE_OVERLAP  <= ovl_w;
      BAD_OFFSET     <= bad_w;
    end
  end

  // engine: one byte per cycle, parameters rechecked at start
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_ff <= ST_IDLE;
      inst_ff  <= 5'h00;
      src_ff   <= 9'h000;
      dst_ff   <= 9'h000;
      left_ff  <= 9'h000;
      copy_ff  <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (any_pend && !err_w[pick])
          begin
            inst_ff  <= pick;
            src_ff   <= sstart_w[pick*9 +: 9];
            dst_ff   <= dstart_w[pick*9 +: 9];
            left_ff  <= cnt_mem[pick][8:0];
            copy_ff  <= cfg_mem[pick][`MBT_CFG_COPY];
            state_ff <= cfg_mem[pick][`MBT_CFG_COPY] ? ST_MOVE : ST_FRD;
          end
        ST_FRD:
          state_ff <= ST_MOVE;
        ST_MOVE:
        begin
          src_ff  <= src_ff + 9'h001;
          dst_ff  <= dst_ff + 9'h001;
          left_ff <= left_ff - 9'h001;
          if (last_w)
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // the one source byte of a fill is read once and held
  always @(posedge MCLK)
  begin
    if (state_ff == ST_FRD)
      fill_ff <= mark_mem[src_ff];
  end

  // bus write channel state
  reg  [11:0] aw_addr_ff;
  reg         aw_full_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;
  reg         w_full_ff;
  wire        wr_go   = aw_full_ff && w_full_ff && !S_AXI_BVALID;
  wire        wr_inst = aw_addr_ff[11:9] == `MBT_WIN_INST;
  wire [4:0]  wr_idx  = aw_addr_ff[8:4];
  wire [8:0]  wr_mix  = aw_addr_ff[10:2];
  wire        wr_mem  = aw_addr_ff[11] == `MBT_MEM_SEL && {11'h000, wr_mix} < `MBT_MEM_BYTES;

  // marker memory: the engine write lands after a same-cycle bus write
  always @(posedge MCLK)
  begin
    if (wr_go && wr_mem && w_strb_ff[0])
      mark_mem[wr_mix] <= w_data_ff[7:0];
    if (state_ff == ST_MOVE)
      mark_mem[dst_ff] <= copy_ff ? mark_mem[src_ff] : fill_ff;
  end

  // instance parameter registers, byte lanes honoured
  integer j;
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (j = 0; j < `MBT_INST; j = j + 1)
      begin
        cfg_mem[j] <= `MBT_CFG_RST;
        src_mem[j] <= 16'h0000;
        dst_mem[j] <= 16'h0000;
        cnt_mem[j] <= 16'h0000;
      end
      PARAM_VISIBLE <= 32'h00000000;
    end
    else
    begin
      for (j = 0; j < `MBT_INST; j = j + 1)
        PARAM_VISIBLE[j] <= cfg_mem[j][`MBT_CFG_VIS];
      if (wr_go && wr_inst)
        case (aw_addr_ff[3:2])
          `MBT_REG_CFG:
            if (w_strb_ff[0]) cfg_mem[wr_idx] <= w_data_ff[7:0];
          `MBT_REG_SRC:
          begin
            if (w_strb_ff[0]) src_mem[wr_idx][7:0]  <= w_data_ff[7:0];
            if (w_strb_ff[1]) src_mem[wr_idx][15:8] <= w_data_ff[15:8];
          end
          `MBT_REG_DST:
          begin
            if (w_strb_ff[0]) dst_mem[wr_idx][7:0]  <= w_data_ff[7:0];
            if (w_strb_ff[1]) dst_mem[wr_idx][15:8] <= w_data_ff[15:8];
          end
          default:
          begin
            if (w_strb_ff[0]) cnt_mem[wr_idx][7:0]  <= w_data_ff[7:0];
            if (w_strb_ff[1]) cnt_mem[wr_idx][15:8] <= w_data_ff[15:8];
          end
        endcase
    end
  end

  // write handshake: address and data taken in either order
  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_addr_ff    <= 12'h000;
      aw_full_ff    <= 1'b0;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      w_full_ff     <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `MBT_RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_full_ff && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY  <= !w_full_ff && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_addr_ff <= S_AXI_AWADDR;
        aw_full_ff <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_data_ff <= S_AXI_WDATA;
        w_strb_ff <= S_AXI_WSTRB;
        w_full_ff <= 1'b1;
      end
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_inst || wr_mem) ? `MBT_RESP_OKAY : `MBT_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        aw_full_ff    <= 1'b0;
        w_full_ff     <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // read path: the word is formed in the cycle the address is taken
  wire [4:0]  rd_idx  = S_AXI_ARADDR[8:4];
  wire [8:0]  rd_mix  = S_AXI_ARADDR[10:2];
  wire        rd_inst = S_AXI_ARADDR[11:9] == `MBT_WIN_INST;
  wire        rd_mem  = S_AXI_ARADDR[11] == `MBT_MEM_SEL && {11'h000, rd_mix} < `MBT_MEM_BYTES;
  reg  [31:0] rd_data;
  reg         rd_ok;
  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    if (rd_inst)
      case (S_AXI_ARADDR[3:2])
        `MBT_REG_CFG: rd_data = {24'h000000, cfg_mem[rd_idx]};
        `MBT_REG_SRC: rd_data = {16'h0000, src_mem[rd_idx]};
        `MBT_REG_DST: rd_data = {16'h0000, dst_mem[rd_idx]};
        default:      rd_data = {16'h0000, cnt_mem[rd_idx]};
      endcase
    else if (rd_mem)
      rd_data = {24'h000000, mark_mem[rd_mix]};
    else if (S_AXI_ARADDR == `MBT_ADDR_BUSY)
      rd_data = BUSY;
    else if (S_AXI_ARADDR == `MBT_ADDR_ERR)
      rd_data = RANGE_EXCEEDED | RANGE_OVERLAP | BAD_OFFSET;
    else
      rd_ok = 1'b0;
  end

  always @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `MBT_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_data;
        S_AXI_RRESP   <= rd_ok ? `MBT_RESP_OKAY : `MBT_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
      else if (!S_AXI_RVALID)
        S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule // mbt_block_mover
`default_nettype wire

/* verif/mbt_block_mover_monitor.sv */
// port-level checks for the marker block mover
// assumes one MCLK domain and an asynchronous active-low RESET_N
`default_nettype none
module mbt_chk (
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic [31:0] TRIGGER,
  input wire logic [31:0] RANGE_EXCEEDED,
  input wire logic [31:0] RANGE_OVERLAP,
  input wire logic [31:0] BAD_OFFSET,
  input wire logic [31:0] BUSY,
  input wire logic [31:0] PARAM_VISIBLE,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // any flag set blocks a start
  logic [31:0] any_flag;
  assign any_flag = RANGE_EXCEEDED | RANGE_OVERLAP | BAD_OFFSET;
  // write walk: both channels taken, one quiet cycle, then the answer
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_wr_answer;
    !S_AXI_BVALID ##1 S_AXI_BVALID;
  endsequence
  property p_wr_resp;
    s_wr_taken |=> s_wr_answer;
  endproperty
  property p_rd_resp;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  property p_aw_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  // a start needs a 0-then-1 trigger sample just before it
  property p_busy_cause;
    (BUSY & ~$past(BUSY) & ~($past(TRIGGER) & ~$past(TRIGGER, 2))) == 32'h0;
  endproperty
  property p_no_flag_start;
    (BUSY & ~$past(BUSY) & $past(any_flag)) == 32'h0;
  endproperty
  property p_flag_excl;
    (BAD_OFFSET & (RANGE_EXCEEDED | RANGE_OVERLAP)) == 32'h0;
  endproperty
  property p_vis_reset;
    $rose(RESET_N) |=> PARAM_VISIBLE == 32'hFFFFFFFF;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_aw_block: assert property (p_aw_block) else $error("write taken early");
  a_busy_cause: assert property (p_busy_cause) else $error("start without edge");
  a_no_flag_start: assert property (p_no_flag_start) else $error("start flagged");
  a_flag_excl: assert property (p_flag_excl) else $error("flags not exclusive");
  a_vis_reset: assert property (p_vis_reset) else $error("visibility reset");
endmodule // mbt_chk
bind mbt_block_mover mbt_chk u_chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .TRIGGER(TRIGGER), .RANGE_EXCEEDED(RANGE_EXCEEDED),
  .RANGE_OVERLAP(RANGE_OVERLAP), .BAD_OFFSET(BAD_OFFSET), .BUSY(BUSY),
  .PARAM_VISIBLE(PARAM_VISIBLE), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY)
);
`default_nettype wire

/* verif/mbt_trig_model.sv */
// controlling side: raises and lowers one trigger line on request
// assumes requests arrive just after a rising MCLK edge
`default_nettype none
module mbt_trig_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  sel,
  input  wire logic        set,
  input  wire logic        clr,
  output var  logic [31:0] trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels move only on an edge, so each rise is one clean 0-then-1 sample
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trig <= 32'h00000000;
    else if (set)
      trig[sel] <= 1'h1;
    else if (clr)
      trig[sel] <= 1'h0;
  end
endmodule // mbt_trig_model
`default_nettype wire

/* verif/tb.sv */
// bench for the marker block mover: bus tasks, copy, fill, error flags
// assumes the trigger model and the bound monitor are compiled alongside
`include "mbt_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0;
  logic        reset_n = 0;
  logic [31:0] trigger, exceeded, overlap, bad, busy, vis, wdat = 0, rdata;
  logic [11:0] awaddr = 0, araddr = 0;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wrd, bv, arr, rv;
  logic [1:0]  bresp, rresp, b_seen;
  logic [4:0]  t_sel = 0;
  logic        t_set = 0, t_clr = 0;
  int          err_total = 0, n_compared = 0;
  mbt_block_mover DUT (.MCLK(mclk), .RESET_N(reset_n), .TRIGGER(trigger),
    .RANGE_EXCEEDED(exceeded), .RANGE_OVERLAP(overlap), .BAD_OFFSET(bad), .BUSY(busy),
    .PARAM_VISIBLE(vis), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdat), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  mbt_trig_model u_trig (.clk(mclk), .rst_n(reset_n), .sel(t_sel), .set(t_set),
    .clr(t_clr), .trig(trigger));
  // 125 MHz clock
  always #4 mclk = ~mclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ready is delayed on purpose so the slave must hold its answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdat <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (awr)
        awv <= 1'h0;
      if (wrd)
        wv <= 1'h0;
    end while ((awv && !awr) || (wv && !wrd));
    repeat (3) @(posedge mclk);
    bre <= 1'h1;
    do @(posedge mclk); while (!bv);
    b_seen = bresp;
    bre <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arv <= 1'h1;
    do @(posedge mclk); while (!arr);
    arv <= 1'h0;
    repeat (2) @(posedge mclk);
    rre <= 1'h1;
    do @(posedge mclk); while (!rv);
    d = rdata;
    r = rresp;
    rre <= 1'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask
  function automatic logic [11:0] mad(input int m);
    return 12'h800 + 12'(m * 4);
  endfunction
  // operands of one instance, then cfg last; flags lag a cycle
  task automatic setup(input int i, input logic [15:0] s, input logic [15:0] d,
                       input logic [15:0] n, input logic [7:0] cfg);
    wr(12'(i * 16 + 4), {16'h0000, s});
    wr(12'(i * 16 + 8), {16'h0000, d});
    wr(12'(i * 16 + 12), {16'h0000, n});
    wr(12'(i * 16), {24'h000000, cfg});
    repeat (2) @(posedge mclk);
  endtask
  // one trigger rise, trigger lowered again afterwards
  task automatic run(input int i, input logic exp_busy);
    int n;
    t_sel <= 5'(i);
    t_set <= 1'h1;
    @(posedge mclk);
    t_set <= 1'h0;
    repeat (2) @(posedge mclk);
    #1 chk({31'h0, busy[i]}, {31'h0, exp_busy});
    for (n = 0; n < 800 && busy[i] !== 1'h0; n++)
      @(posedge mclk);
    repeat (10) @(posedge mclk);
    chk({31'h0, busy[i]}, 32'h0);
    t_clr <= 1'h1;
    @(posedge mclk);
    t_clr <= 1'h0;
  endtask
  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
    rdc(12'h010, 32'h00000002);
    chk(vis, 32'hFFFFFFFF);
    chk(bad, 32'hFFFFFFFF);
    rd(12'h300, d, r);
    chk({30'h0, r}, {30'h0, `MBT_RESP_SLVERR});
    wr(12'h300, 32'h00000000);
    chk({30'h0, b_seen}, {30'h0, `MBT_RESP_SLVERR});
    $display("test reset and map done");
    for (int m = 0; m < 8; m++)
      wr(mad(m), 32'hA0 + 32'(m));
    wr(mad(378), 32'h0000005A);
    // copy byte marker 1 to the last five bytes of memory
    setup(1, 16'h0001, 16'h017B, 16'h0005, 8'h13);
    chk({exceeded[1], overlap[1], bad[1]}, 32'h0);
    run(1, 1'h1);
    for (int k = 0; k < 5; k++)
      rdc(mad(379 + k), 32'hA0 + 32'(k));
    rdc(mad(378), 32'h0000005A);
    $display("test copy done");
    // fill from word marker 3 into dword marker 51 on the top instance
    setup(31, 16'h0003, 16'h0033, 16'h0006, 8'hE2);
    run(31, 1'h1);
    for (int k = 0; k < 6; k++)
      rdc(mad(200 + k), 32'h000000A4);
    $display("test fill done");
    // past the end, overlapping, count too large
    setup(3, 16'h0000, 16'h017C, 16'h0005, 8'h03);
    chk({exceeded[3], overlap[3], bad[3]}, 32'h4);
    run(3, 1'h0);
    setup(3, 16'h000A, 16'h000C, 16'h0005, 8'h03);
    chk({exceeded[3], overlap[3], bad[3]}, 32'h2);
    setup(3, 16'h0000, 16'h0064, 16'h0180, 8'h03);
    chk({exceeded[3], overlap[3], bad[3]}, 32'h1);
    rdc(mad(380), 32'h000000A1);
    rdc(12'h204, 32'h7FFFFFFD);
    rdc(12'h200, 32'h00000000);
    wr(12'h000, 32'h00000001);
    chk({30'h0, b_seen}, {30'h0, `MBT_RESP_OKAY});
    repeat (2) @(posedge mclk);
    chk(vis, 32'hFFFFFFFE);
    $display("test error flags done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
